// >>> verilog/timer_pkg.sv
// Constants for the dual byte timer/counter with capture.
// Assumes a single 125 MHz clock and word-wide AHB-Lite access.
package timer_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 x index)
	// ----------------------------------------
	localparam logic [15:0] IDX_TIMER_CONTROL   = 16'hfe10;
	localparam logic [15:0] IDX_PRESCALER_MATCH = 16'hfe11;
	localparam logic [15:0] IDX_COUNT_LOW       = 16'hfe12;
	localparam logic [15:0] IDX_COUNT_HIGH      = 16'hfe13;
	localparam logic [15:0] IDX_MATCH_DATA_LOW  = 16'hfe14;
	localparam logic [15:0] IDX_MATCH_DATA_HIGH = 16'hfe15;
	localparam logic [15:0] IDX_CAPTURE_LOW     = 16'hfe16;
	localparam logic [15:0] IDX_CAPTURE_HIGH    = 16'hfe17;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int unsigned BIT_HIGH_RUN           = 7;
	localparam int unsigned BIT_LOW_RUN            = 6;
	localparam int unsigned BIT_WIDE_MODE          = 5;
	localparam int unsigned BIT_LOW_EXTERNAL_CLOCK = 4;
	localparam int unsigned BIT_HIGH_MATCH_FLAG    = 3;
	localparam int unsigned BIT_HIGH_IRQ_ENABLE    = 2;
	localparam int unsigned BIT_LOW_MATCH_FLAG     = 1;
	localparam int unsigned BIT_LOW_IRQ_ENABLE     = 0;

	// ----------------------------------------
	// Reset values and fixed figures
	// ----------------------------------------
	localparam logic [7:0]  RESET_TIMER_CONTROL   = 8'h00;
	localparam logic [7:0]  RESET_PRESCALER_MATCH = 8'h00;
	localparam logic [7:0]  RESET_COUNT           = 8'h00;
	localparam logic [7:0]  RESET_MATCH_DATA      = 8'h00;
	localparam logic [7:0]  COUNT_TOP             = 8'hff;
	localparam logic [13:0] ADDR_TOP_ZERO         = 14'h0000;
	localparam logic [1:0]  HRESP_OKAY            = 2'h0;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ_WAIT,
		BUS_READ_DONE
	} bus_state_type;

endpackage

// >>> verilog/dual_byte_timer.sv
// Dual byte timer/counter with prescaler, match buffers and capture.
// Assumes an AHB-Lite master on clk and event/capture strobes that are
// already one-cycle pulses on clk.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps

module dual_byte_timer
	import timer_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	// Timer events and power state
	input  wire logic        ext_event,
	input  wire logic        capture_low_strobe,
	input  wire logic        capture_high_strobe,
	input  wire logic        hold_mode,
	// Interrupt requests
	output logic             irq_low,
	output logic             irq_high
);

	// ----------------------------------------
	// Address decode helpers
	// ----------------------------------------
	function automatic logic [15:0] word_index(input logic [31:0] addr);
		word_index = addr[17:2];
	endfunction

	function automatic logic index_mapped(input logic [31:0] addr);
		logic [15:0] idx;
		idx = addr[17:2];
		index_mapped = (addr[31:18] == ADDR_TOP_ZERO) && (addr[1:0] == 2'h0)
			&& (idx >= IDX_TIMER_CONTROL) && (idx <= IDX_CAPTURE_HIGH);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	bus_state_type state;
	bus_state_type next_state;
	logic [15:0]   addr_q;
	logic          hit_q;

	logic [7:0] timer_control;
	logic [7:0] prescaler_match;
	logic [7:0] count_low;
	logic [7:0] count_high;
	logic [7:0] match_data_low;
	logic [7:0] match_data_high;
	logic [7:0] capture_low;
	logic [7:0] capture_high;
	logic [7:0] low_buf;
	logic [7:0] high_buf;
	logic [7:0] pre_cnt;

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	wire take = hsel && htrans[1] && hready;
	wire wr   = (state == BUS_WRITE) && hit_q;

	wire wr_control   = wr && (addr_q == IDX_TIMER_CONTROL);
	wire wr_prescaler = wr && (addr_q == IDX_PRESCALER_MATCH);
	wire wr_data_low  = wr && (addr_q == IDX_MATCH_DATA_LOW);
	wire wr_data_high = wr && (addr_q == IDX_MATCH_DATA_HIGH);

	// Reads take one wait state so a read right after a write sees it
	assign hreadyout = (state != BUS_READ_WAIT);
	assign hresp     = HRESP_OKAY;

	always_comb begin
		next_state = state;
		unique case (state)
			BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
				if (take) begin
					next_state = hwrite ? BUS_WRITE : BUS_READ_WAIT;
				end else begin
					next_state = BUS_IDLE;
				end
			end
			BUS_READ_WAIT: begin
				next_state = BUS_READ_DONE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state  <= BUS_IDLE;
			addr_q <= 16'h0000;
			hit_q  <= 1'b0;
		end else begin
			state <= next_state;
			if (take) begin
				addr_q <= word_index(haddr);
				hit_q  <= index_mapped(haddr);
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [7:0] read_byte;
	always_comb begin
		unique case (addr_q)
			IDX_TIMER_CONTROL:   read_byte = timer_control;
			IDX_PRESCALER_MATCH: read_byte = prescaler_match;
			IDX_COUNT_LOW:       read_byte = count_low;
			IDX_COUNT_HIGH:      read_byte = count_high;
			IDX_MATCH_DATA_LOW:  read_byte = match_data_low;
			IDX_MATCH_DATA_HIGH: read_byte = match_data_high;
			IDX_CAPTURE_LOW:     read_byte = capture_low;
			IDX_CAPTURE_HIGH:    read_byte = capture_high;
			default:             read_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (state == BUS_READ_WAIT) begin
			hrdata <= hit_q ? {24'h00_0000, read_byte} : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	wire high_run           = timer_control[BIT_HIGH_RUN];
	wire low_run            = timer_control[BIT_LOW_RUN];
	wire wide_mode          = timer_control[BIT_WIDE_MODE];
	wire low_external_clock = timer_control[BIT_LOW_EXTERNAL_CLOCK];
	wire high_match_flag    = timer_control[BIT_HIGH_MATCH_FLAG];
	wire high_irq_enable    = timer_control[BIT_HIGH_IRQ_ENABLE];
	wire low_match_flag     = timer_control[BIT_LOW_MATCH_FLAG];
	wire low_irq_enable     = timer_control[BIT_LOW_IRQ_ENABLE];

	assign irq_high = high_irq_enable && high_match_flag;
	assign irq_low  = low_irq_enable && low_match_flag;

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	wire pre_match = !hold_mode && (pre_cnt == prescaler_match);

	wire [7:0] next_pre_cnt = wr_prescaler ? RESET_COUNT
		: hold_mode ? pre_cnt
		: pre_match ? RESET_COUNT
		: 8'(pre_cnt + 8'h01);

	// ----------------------------------------
	// Counter halves
	// ----------------------------------------
	// Event strobes are counted directly, one per high cycle
	wire low_tick   = low_external_clock ? ext_event : pre_match;
	wire low_equal  = (count_low == low_buf);
	wire high_equal = (count_high == high_buf);

	wire wide_match = wide_mode && low_run && low_tick && low_equal && high_equal;
	wire low_match  = wide_mode ? wide_match : (low_run && low_tick && low_equal);
	wire high_tick  = wide_mode ? (low_tick && (count_low == COUNT_TOP)) : pre_match;
	wire high_match = wide_mode ? wide_match : (high_run && pre_match && high_equal);

	wire [7:0] next_count_low = (!low_run || low_match) ? RESET_COUNT
		: low_tick ? 8'(count_low + 8'h01)
		: count_low;
	wire [7:0] next_count_high = (!high_run || high_match) ? RESET_COUNT
		: high_tick ? 8'(count_high + 8'h01)
		: count_high;

	// Buffer lags the data register by one cycle while stopped
	wire [7:0] next_low_buf  = (!low_run || low_match) ? match_data_low : low_buf;
	wire [7:0] next_high_buf = (!high_run || high_match) ? match_data_high : high_buf;

	// Flags: a match in the same cycle as a software clear wins
	logic [7:0] next_control;
	always_comb begin
		next_control = wr_control ? hwdata[7:0] : timer_control;
		if (high_match) begin
			next_control[BIT_HIGH_MATCH_FLAG] = 1'b1;
		end
		if (low_match) begin
			next_control[BIT_LOW_MATCH_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_control   <= RESET_TIMER_CONTROL;
			prescaler_match <= RESET_PRESCALER_MATCH;
			match_data_low  <= RESET_MATCH_DATA;
			match_data_high <= RESET_MATCH_DATA;
			pre_cnt         <= RESET_COUNT;
			count_low       <= RESET_COUNT;
			count_high      <= RESET_COUNT;
			low_buf         <= RESET_MATCH_DATA;
			high_buf        <= RESET_MATCH_DATA;
		end else begin
			timer_control <= next_control;
			if (wr_prescaler) begin
				prescaler_match <= hwdata[7:0];
			end
			if (wr_data_low) begin
				match_data_low <= hwdata[7:0];
			end
			if (wr_data_high) begin
				match_data_high <= hwdata[7:0];
			end
			pre_cnt    <= next_pre_cnt;
			count_low  <= next_count_low;
			count_high <= next_count_high;
			low_buf    <= next_low_buf;
			high_buf   <= next_high_buf;
		end
	end

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	// In wide mode both bytes are taken together on the high strobe
	wire take_low_capture = wide_mode ? capture_high_strobe : capture_low_strobe;

	// No reset: contents are undefined until the first strobe
	always_ff @(posedge clk) begin
		if (take_low_capture) begin
			capture_low <= count_low;
		end
		if (capture_high_strobe) begin
			capture_high <= count_high;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_high_stop_zero: assert property (!high_run |=> count_high == 8'h00)
		else $error("high count not zero while stopped");
	a_high_buf_follow: assert property (!high_run |=> high_buf == $past(match_data_high))
		else $error("high buffer not following data while stopped");
	a_high_buf_hold: assert property (high_run && !high_match |=> $stable(high_buf))
		else $error("high buffer changed without match");
	a_low_stop_zero: assert property (!low_run |=> count_low == 8'h00)
		else $error("low count not zero while stopped");
	a_low_buf_hold: assert property (low_run && !low_match |=> $stable(low_buf))
		else $error("low buffer changed without match");
	a_wide_match_full: assert property (wide_mode && low_run && high_run && low_tick
		&& low_equal && !high_equal |=> count_low == 8'(($past(count_low) + 8'h01)))
		else $error("wide mode matched on low byte alone");
	a_ext_count_step: assert property (low_run && !wide_mode && low_external_clock && ext_event
		&& !low_match |=> count_low == 8'(($past(count_low) + 8'h01)))
		else $error("external event not counted");
	a_ext_ignores_pre: assert property (low_run && low_external_clock && !ext_event
		|=> count_low == $past(count_low))
		else $error("low count moved without external event");
	a_high_flag_set: assert property (high_match |=> high_match_flag)
		else $error("high flag not set on match");
	a_low_flag_set: assert property (low_match |=> low_match_flag)
		else $error("low flag not set on match");
	a_high_irq_raise: assert property (high_match && high_irq_enable && !wr_control |=> irq_high)
		else $error("high irq missing");
	a_low_irq_raise: assert property (low_match && low_irq_enable && !wr_control |=> irq_low)
		else $error("low irq missing");
	a_wide_both_flags: assert property (wide_match |=> low_match_flag && high_match_flag)
		else $error("wide match did not set both flags");
	a_pre_restart: assert property (pre_match |=> pre_cnt == 8'h00)
		else $error("prescaler not restarted on match");
	a_pre_write: assert property (wr_prescaler |=> pre_cnt == 8'h00)
		else $error("prescaler not restarted on write");
	a_pre_hold: assert property (hold_mode && !wr_prescaler |=> $stable(pre_cnt))
		else $error("prescaler moved in hold");
	a_high_wrap: assert property (wide_mode && high_run && low_run && low_tick && count_low == 8'hff
		&& !wide_match |=> count_high == 8'(($past(count_high) + 8'h01)))
		else $error("high byte missed low wrap");
	a_cap_high: assert property (capture_high_strobe |=> capture_high == $past(count_high))
		else $error("high capture wrong");
	a_cap_low: assert property (capture_low_strobe && !wide_mode |=> capture_low == $past(count_low))
		else $error("low capture wrong");

	// ----------------------------------------
	// Reload, restart and step checks
	// ----------------------------------------
	// Flag keep checks leave out software writes, which may clear or set
	// Step checks leave out the match cycle, where the half restarts
	a_low_buf_follow: assert property (!low_run |=> low_buf == $past(match_data_low))
		else $error("low buffer not following data while stopped");
	a_low_buf_reload: assert property (low_match |=> low_buf == $past(match_data_low))
		else $error("low buffer not reloaded on match");
	a_high_buf_reload: assert property (high_match |=> high_buf == $past(match_data_high))
		else $error("high buffer not reloaded on match");
	a_low_match_zero: assert property (low_match |=> count_low == 8'h00)
		else $error("low count not restarted on match");
	a_high_match_zero: assert property (high_match |=> count_high == 8'h00)
		else $error("high count not restarted on match");
	a_low_flag_keep: assert property (!low_match && !wr_control
		|=> $stable(low_match_flag))
		else $error("low flag changed without match or write");
	a_high_flag_keep: assert property (!high_match && !wr_control
		|=> $stable(high_match_flag))
		else $error("high flag changed without match or write");
	a_pre_count: assert property (!hold_mode && !pre_match && !wr_prescaler
		|=> pre_cnt == 8'(($past(pre_cnt) + 8'h01)))
		else $error("prescaler did not advance");
	a_low_pre_step: assert property (low_run && !wide_mode && !low_external_clock && pre_match && !low_match
		|=> count_low == 8'(($past(count_low) + 8'h01)))
		else $error("low count missed prescaler pulse");
	a_high_pre_step: assert property (high_run && !wide_mode && pre_match && !high_match
		|=> count_high == 8'(($past(count_high) + 8'h01)))
		else $error("high count missed prescaler pulse");
	a_wide_high_hold: assert property (wide_mode && high_run && !wide_match && !(low_tick && count_low == COUNT_TOP)
		|=> $stable(count_high))
		else $error("high byte moved without low wrap");
	a_cap_wide: assert property (wide_mode && capture_high_strobe
		|=> capture_low == $past(count_low))
		else $error("low capture missed in wide mode");
	a_hold_no_tick: assert property (hold_mode |-> !pre_match)
		else $error("prescaler pulse during hold");
	a_read_wait: assert property (hreadyout && take && !hwrite |=> !hreadyout)
		else $error("read data phase without wait state");
	a_write_no_wait: assert property (hreadyout && take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_stop_no_low_match: assert property (!low_run |-> !low_match)
		else $error("low match while stopped");
	a_stop_no_high_match: assert property (!high_run && !wide_mode |-> !high_match)
		else $error("high match while stopped");

	c_low_match: cover property (low_run && !wide_mode && low_match);
	c_wide_match: cover property (wide_match);
	c_ext_count: cover property (low_external_clock && low_run && ext_event);
	c_flag_irq: cover property (irq_high && irq_low);
	c_hold_freeze: cover property (hold_mode && low_run && !low_external_clock);

endmodule // dual_byte_timer

// >>> verif/dual_byte_timer_counter_capture_tb_top.sv
// Self-checking bench for the dual byte timer/counter with capture.
// Drives the AHB-Lite slave, event, capture and hold inputs itself.
`timescale 1ns/1ps

module dual_byte_timer_counter_capture_tb_top
	import timer_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic [1:0]  hresp;
	logic        ext_event;
	logic        cap_lo;
	logic        cap_hi;
	logic        hold_mode;
	logic        irq_low;
	logic        irq_high;
	logic        rd_busy;
	int          miscompares;
	int          n_compared;
	int          seed;
	int          p;
	int          n;
	int          h;
	logic [7:0]  d;
	logic [31:0] exp_q[$];
	string       nm_q[$];

	dual_byte_timer i_dual_byte_timer (
		.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_event(ext_event),
		.capture_low_strobe(cap_lo), .capture_high_strobe(cap_hi),
		.hold_mode(hold_mode), .irq_low(irq_low), .irq_high(irq_high)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Address phase held until hready, then data phase held until hready
	task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] v);
		haddr <= {14'h0000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h000000, v};
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] v);
		bus(idx, 1'b1, v);
	endtask

	task automatic rd(input logic [15:0] idx, input logic [7:0] e);
		exp_q.push_back({24'h000000, e});
		nm_q.push_back($sformatf("register %h", idx));
		bus(idx, 1'b0, 8'h00);
	endtask

	// One count per cycle held high, then one settling edge
	task automatic ev(input int cnt);
		repeat (cnt) begin
			ext_event <= 1'b1;
			@(posedge clk);
		end
		ext_event <= 1'b0;
		@(posedge clk);
	endtask

	task automatic irq_is(input logic lo, input logic hi);
		@(negedge clk);
		check("irq_low", {31'h0, irq_low}, {31'h0, lo});
		check("irq_high", {31'h0, irq_high}, {31'h0, hi});
		@(posedge clk);
	endtask

	task report_and_stop;
		if (exp_q.size() != 0)
			miscompares++;
		$display("comparisons %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Read monitor: oldest note against each completed read
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_busy <= 1'b0;
		end else begin
			if (rd_busy && hreadyout) begin
				if (exp_q.size() == 0)
					miscompares++;
				else
					check(nm_q.pop_front(), hrdata, exp_q.pop_front());
				check("hresp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
			end
			if (hsel && htrans[1] && hreadyout && !hwrite)
				rd_busy <= 1'b1;
			else if (hreadyout)
				rd_busy <= 1'b0;
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h5c2e;
		rst_n = 1'b0;
		hsel = 1'b1;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h00000000;
		ext_event = 1'b0;
		cap_lo = 1'b0;
		cap_hi = 1'b0;
		hold_mode = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			rd(IDX_TIMER_CONTROL + 16'(i), 8'h00);
		irq_is(1'b0, 1'b0);
		// Read-only and unmapped places ignore writes
		wr(IDX_COUNT_LOW, 8'h5a);
		wr(16'hfe18, 8'hff);
		rd(IDX_COUNT_LOW, 8'h00);
		rd(16'hfe18, 8'h00);
		rd(IDX_TIMER_CONTROL, 8'h00);
		d = 8'($random(seed));
		wr(IDX_MATCH_DATA_HIGH, d);
		rd(IDX_MATCH_DATA_HIGH, d);
		$display("test register access done");

		// Event counting; a mid-period write waits for the match
		wr(IDX_MATCH_DATA_LOW, 8'h04);
		wr(IDX_TIMER_CONTROL, 8'h50);
		ev(2);
		wr(IDX_MATCH_DATA_LOW, 8'h06);
		ev(3);
		rd(IDX_COUNT_LOW, 8'h00);
		rd(IDX_TIMER_CONTROL, 8'h52);
		ev(5);
		rd(IDX_COUNT_LOW, 8'h05);
		wr(IDX_TIMER_CONTROL, 8'h51);
		irq_is(1'b0, 1'b0);
		ev(2);
		irq_is(1'b1, 1'b0);
		wr(IDX_TIMER_CONTROL, 8'h10);
		rd(IDX_COUNT_LOW, 8'h00);
		$display("test event counting done");

		// Prescaler period, restart on write, hold freeze, capture
		wr(IDX_MATCH_DATA_LOW, 8'hff);
		wr(IDX_MATCH_DATA_HIGH, 8'hff);
		for (int k = 0; k < 3; k++) begin
			p = (k == 0) ? 0 : ($random(seed) & 7);
			n = 20 + ($random(seed) & 15);
			h = (k == 2) ? 5 : 0;
			wr(IDX_PRESCALER_MATCH, 8'hff);
			wr(IDX_TIMER_CONTROL, 8'hc0);
			wr(IDX_PRESCALER_MATCH, 8'(p));
			if (h > 0) begin
				hold_mode <= 1'b1;
				repeat (h) @(posedge clk);
				hold_mode <= 1'b0;
			end
			repeat (n - 1 - h) @(posedge clk);
			cap_lo <= 1'b1;
			cap_hi <= 1'b1;
			@(posedge clk);
			cap_lo <= 1'b0;
			cap_hi <= 1'b0;
			wr(IDX_TIMER_CONTROL, 8'h00);
			rd(IDX_CAPTURE_LOW, 8'((n - 1 - h) / (p + 1)));
			rd(IDX_CAPTURE_HIGH, 8'((n - 1 - h) / (p + 1)));
			rd(IDX_COUNT_HIGH, 8'h00);
		end
		$display("test prescaler and capture done");

		// Wide mode: sixteen-bit match sets both flags together
		wr(IDX_MATCH_DATA_LOW, 8'h03);
		wr(IDX_MATCH_DATA_HIGH, 8'h01);
		wr(IDX_TIMER_CONTROL, 8'hf5);
		ev(259);
		rd(IDX_COUNT_LOW, 8'h03);
		rd(IDX_COUNT_HIGH, 8'h01);
		rd(IDX_TIMER_CONTROL, 8'hf5);
		ev(1);
		rd(IDX_TIMER_CONTROL, 8'hff);
		rd(IDX_COUNT_LOW, 8'h00);
		rd(IDX_COUNT_HIGH, 8'h00);
		irq_is(1'b1, 1'b1);
		wr(IDX_TIMER_CONTROL, 8'h30);
		irq_is(1'b0, 1'b0);
		$display("test wide mode done");
		report_and_stop();
	end
endmodule // dual_byte_timer_counter_capture_tb_top
